// *** pscr_pkg.sv ***
// Purpose: shared constants and carrier types for the strap configuration and reset block
// Assumes: 200 MHz system clock
// Notes: register offsets are indices on the plain register port
package pscr_pkg;

    // register indices on the plain port
    localparam logic [4:0] ADDR_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_PHY_CONFIG    = 5'h13;
    localparam logic [4:0] ADDR_STRAP_STATUS  = 5'h1e;

    // field positions
    localparam int BC_LOOPBACK_BIT  = 14;
    localparam int BC_AUTONEG_BIT   = 12;
    localparam int PC_MLT3_BYP_BIT  = 1;

    // values after reset before straps load
    localparam logic [15:0] BASIC_CONTROL_RST = 16'h0000;
    localparam logic [15:0] PHY_CONFIG_RST    = 16'h0000;

    // reset sequencing timing
    localparam int RESET_SETTLE_NS     = 1000;
    localparam int CLK_PERIOD_NS       = 5;
    localparam int RESET_SETTLE_CYCLES = (RESET_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STRAP_SAMPLE_CYCLES = 4;
    localparam int CNT_W               = 8;

    // straps captured at reset
    typedef struct packed {
        logic autoneg;
        logic config_a;
        logic config_b;
        logic reduced_if;
        logic mdix_dis;
    } pscr_strap_s;

    // advertised ability summary
    typedef struct packed {
        logic adv_100_fd;
        logic adv_100_hd;
        logic adv_10_fd;
        logic adv_10_hd;
    } pscr_adv_s;

    typedef enum logic [1:0] {
        PSCR_HOLD,
        PSCR_SAMPLE,
        PSCR_SETTLE,
        PSCR_DONE
    } pscr_state_e;

endpackage

// *** pscr_rst_sync.sv ***
// Purpose: two flip-flop release of the asynchronous reset
// Assumes: active-low reset input
// Notes: assertion is immediate, release is delayed two edges
`timescale 1ns/1ps
module pscr_rst_sync
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // synchronised reset
    output logic      rst_n_o
);
    logic stage1;
    logic stage2;

    // release chain; only the second stage is used
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end
        else
        begin
            stage1 <= 1'b1;
            stage2 <= stage1;
        end
    end

    assign rst_n_o = stage2;
endmodule

// *** pscr_mdc_edge.sv ***
// Purpose: detects a management clock transition
// Assumes: mdc is synchronous to clk_i
// Notes: flags level change against the previous sample
`timescale 1ns/1ps
module pscr_mdc_edge
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n,
    // management clock sample
    input  wire logic mdc_i,
    // one-cycle transition pulse
    output logic      edge_o
);
    logic prev;
    logic next_prev;

    // next value of the delayed sample
    always_comb
    begin
        next_prev = mdc_i;
    end

    // registered sample
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            prev <= 1'b0;
        else
            prev <= next_prev;
    end

    assign edge_o = prev ^ mdc_i;
endmodule

// *** pscr_top.sv ***
// Purpose: strap configuration and reset status of a 10/100 transceiver
// Assumes: straps and mdc are synchronous to clk_i; registers reached over a plain port
// Notes: reset-done output rises only after straps are loaded and settle time has passed
`timescale 1ns/1ps
module pscr_top
(
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    // straps and test pins
    input  wire logic                 autoneg_strap_i,
    input  wire logic                 strap_config_a_i,
    input  wire logic                 strap_config_b_i,
    input  wire logic                 reduced_if_select_i,
    input  wire logic                 mdix_dis_i,
    input  wire logic                 test_i,
    input  wire logic                 scan_enable_pin_i,
    // management clock
    input  wire logic                 mdc_i,
    // register port
    input  wire logic [4:0]           reg_addr_i,
    input  wire logic [15:0]          reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output logic      [15:0]          reg_rdata_o,
    // status and control outputs
    output logic                      reset_done_o,
    output logic                      mlt3_bypass_o,
    output logic                      loopback_o,
    output logic                      autoneg_en_o,
    output logic                      auto_mdix_en_o,
    output logic                      reduced_if_o,
    output pscr_pkg::pscr_adv_s       adv_o
);
    import pscr_pkg::*;

    logic        rst_n;
    logic        mdc_edge;
    pscr_state_e state;
    pscr_state_e next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic        mdc_seen;
    logic        next_mdc_seen;
    pscr_strap_s strap;
    pscr_strap_s next_strap;
    logic [15:0] basic_control;
    logic [15:0] next_basic_control;
    logic [15:0] phy_config;
    logic [15:0] next_phy_config;
    logic [15:0] rdata;
    logic [15:0] next_rdata;
    logic        done;
    logic        next_done;
    pscr_adv_s   adv;
    pscr_adv_s   next_adv;
    logic        an_on;

    // power-up and pin reset both pass through here; flops come up in reset
    pscr_rst_sync u_rst_sync
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .rst_n_o (rst_n)
    );

    // management clock transition detector
    pscr_mdc_edge u_mdc_edge
    (
        .clk_i  (clk_i),
        .rst_n  (rst_n),
        .mdc_i  (mdc_i),
        .edge_o (mdc_edge)
    );

    assign an_on = basic_control[BC_AUTONEG_BIT];

    // reset sequencer: hold, sample straps, settle, done
    always_comb
    begin
        next_state    = state;
        next_cnt      = cnt;
        next_mdc_seen = mdc_seen | mdc_edge;
        next_strap    = strap;
        next_done     = done;
        case (state)
            PSCR_HOLD:
            begin
                next_cnt   = '0;
                next_done  = 1'b0;
                next_state = PSCR_SAMPLE;
            end
            PSCR_SAMPLE:
            begin
                // straps captured repeatedly during the sample window
                next_strap.autoneg    = autoneg_strap_i;
                next_strap.config_a   = strap_config_a_i;
                next_strap.config_b   = strap_config_b_i;
                next_strap.reduced_if = reduced_if_select_i;
                next_strap.mdix_dis   = mdix_dis_i;
                next_cnt = cnt + 1'b1;
                if (cnt == CNT_W'(STRAP_SAMPLE_CYCLES - 1))
                begin
                    next_cnt   = '0;
                    next_state = PSCR_SETTLE;
                end
            end
            PSCR_SETTLE:
            begin
                if (cnt != CNT_W'(RESET_SETTLE_CYCLES - 1))
                    next_cnt = cnt + 1'b1;
                if (cnt == CNT_W'(RESET_SETTLE_CYCLES - 1) && next_mdc_seen)
                begin
                    next_done  = 1'b1;
                    next_state = PSCR_DONE;
                end
            end
            PSCR_DONE:
                next_done = 1'b1;
            default:
                next_state = PSCR_HOLD;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state    <= PSCR_HOLD;
            cnt      <= '0;
            mdc_seen <= 1'b0;
            strap    <= '0;
            done     <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            cnt      <= next_cnt;
            mdc_seen <= next_mdc_seen;
            strap    <= next_strap;
            done     <= next_done;
        end
    end

    // register file: straps loaded at end of sampling, software writes afterwards
    always_comb
    begin
        next_basic_control = basic_control;
        next_phy_config    = phy_config;
        if (state == PSCR_SETTLE && cnt == '0)
        begin
            next_basic_control[BC_AUTONEG_BIT] = strap.autoneg;
            if (!strap.autoneg)
            begin
                next_phy_config[PC_MLT3_BYP_BIT]   = strap.config_a;
                next_basic_control[BC_LOOPBACK_BIT] = strap.config_b;
            end
        end
        else if (done && reg_wr_i)
        begin
            if (reg_addr_i == ADDR_BASIC_CONTROL)
                next_basic_control = reg_wdata_i;
            else if (reg_addr_i == ADDR_PHY_CONFIG)
                next_phy_config = reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            basic_control <= BASIC_CONTROL_RST;
            phy_config    <= PHY_CONFIG_RST;
        end
        else
        begin
            basic_control <= next_basic_control;
            phy_config    <= next_phy_config;
        end
    end

    // advertised abilities from the two straps when autonegotiation is on
    always_comb
    begin
        next_adv = '0;
        if (an_on)
        begin
            case ({strap.config_a, strap.config_b})
                2'b00:   next_adv = 4'hf;
                2'b01:   next_adv = 4'hc;
                2'b10:   next_adv = 4'h3;
                2'b11:   next_adv = 4'h8;
                default: next_adv = '0;
            endcase
        end
    end

    // read data one cycle after the strobe; unmapped reads return zero
    always_comb
    begin
        next_rdata = '0;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                ADDR_BASIC_CONTROL: next_rdata = basic_control;
                ADDR_PHY_CONFIG:    next_rdata = phy_config;
                ADDR_STRAP_STATUS:  next_rdata = {9'h000, test_i | scan_enable_pin_i, done,
                                                  strap};
                default:            next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata          <= '0;
            adv            <= '0;
            reg_rdata_o    <= '0;
            reset_done_o   <= 1'b0;
            mlt3_bypass_o  <= 1'b0;
            loopback_o     <= 1'b0;
            autoneg_en_o   <= 1'b0;
            auto_mdix_en_o <= 1'b0;
            reduced_if_o   <= 1'b0;
            adv_o          <= '0;
        end
        else
        begin
            rdata          <= next_rdata;
            adv            <= next_adv;
            reg_rdata_o    <= next_rdata;
            reset_done_o   <= next_done;
            mlt3_bypass_o  <= phy_config[PC_MLT3_BYP_BIT];
            loopback_o     <= basic_control[BC_LOOPBACK_BIT];
            autoneg_en_o   <= an_on;
            // follows next_done so pair swapping starts on the same edge as reset-done
            auto_mdix_en_o <= next_done & ~mdix_dis_i;
            reduced_if_o   <= strap.reduced_if;
            adv_o          <= next_adv;
        end
    end
endmodule

// *** pscr_props.sv ***
// Purpose: port checks on strap loading and reset-done sequencing
// Assumes: straps hold still while the device is out of reset
// Notes: bound onto the top module from the bench top file
`timescale 1ns/1ps
module pscr_props
(
    // clock and reset
    input wire logic             clk_i,
    input wire logic             rst_n_i,
    // straps and management clock
    input wire logic             autoneg_strap_i,
    input wire logic             strap_config_a_i,
    input wire logic             strap_config_b_i,
    input wire logic             reduced_if_select_i,
    input wire logic             mdix_dis_i,
    input wire logic             mdc_i,
    // watched outputs
    input wire logic             reset_done_o,
    input wire logic             mlt3_bypass_o,
    input wire logic             loopback_o,
    input wire logic             autoneg_en_o,
    input wire logic             auto_mdix_en_o,
    input wire logic             reduced_if_o,
    input wire pscr_pkg::pscr_adv_s adv_o
);
    import pscr_pkg::*;
    logic [8:0] age;
    logic       mdc_q;
    logic       mdc_seen;
    // cycles since release and mdc activity, saturating
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            age      <= 9'h000;
            mdc_q    <= 1'b0;
            mdc_seen <= 1'b0;
        end
        else
        begin
            age      <= (age == 9'h1ff) ? age : age + 9'h001;
            mdc_q    <= mdc_i;
            mdc_seen <= mdc_seen | (mdc_i != mdc_q);
        end
    end
    // advertisement picked by the two config straps
    function automatic logic [3:0] adv_of(input logic a, input logic b);
        case ({a, b})
            2'b00:   return 4'hf;
            2'b01:   return 4'hc;
            2'b10:   return 4'h3;
            default: return 4'h8;
        endcase
    endfunction
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // the moment the device reports itself usable
    sequence s_up;
        $rose(reset_done_o);
    endsequence
    a_done_after_settle: assert property (reset_done_o |-> age >= 9'h0c8)
        else $error("reset-done rose before settle time");
    a_done_needs_mdc: assert property (reset_done_o |-> mdc_seen)
        else $error("reset-done rose without mdc activity");
    a_done_stays_high: assert property (reset_done_o |=> reset_done_o)
        else $error("reset-done dropped without reset");
    a_mlt3_from_strap: assert property (s_up |-> mlt3_bypass_o == (!autoneg_strap_i && strap_config_a_i))
        else $error("line coder bypass not loaded from strap");
    a_loop_from_strap: assert property (s_up |-> loopback_o == (!autoneg_strap_i && strap_config_b_i))
        else $error("loopback not loaded from strap");
    a_adv_from_strap: assert property (s_up ##0 autoneg_strap_i |-> autoneg_en_o
        && adv_o == adv_of(strap_config_a_i, strap_config_b_i))
        else $error("advertisement not taken from straps");
    a_adv_off_zero: assert property (!autoneg_en_o && $past(!autoneg_en_o) |-> adv_o == 4'h0)
        else $error("advertisement shown with autonegotiation off");
    a_mdix_fixed: assert property (mdix_dis_i && $past(mdix_dis_i) |-> !auto_mdix_en_o)
        else $error("pair swapping left on while disabled");
    a_straps_loaded: assert property (s_up |-> reduced_if_o == reduced_if_select_i)
        else $error("reduced interface strap not captured");
endmodule

// *** pscr_board.sv ***
// Purpose: board straps and host management clock around the device
// Assumes: bench sets strap levels only while reset is held
// Notes: mdc parks low when stopped, so no transition is seen then
`timescale 1ns/1ps
module pscr_board
(
    // clock
    input  wire logic       clk_i,
    // strap levels and mdc enable from the bench
    input  wire logic [4:0] straps_i,
    input  wire logic       mdc_run_i,
    // pins into the device
    output logic      [4:0] straps_o,
    output logic            test_o,
    output logic            scan_o,
    output logic            mdc_o
);
    // strap resistors {autoneg, a, b, reduced-if, mdix disable}
    assign straps_o = straps_i;
    // no reference clock is modelled: the block runs from its own clock only
    // test pins grounded
    assign test_o = 1'b0;
    assign scan_o = 1'b0;
    // host mdc toggles while running
    initial mdc_o = 1'b0;
    always @(posedge clk_i)
        mdc_o <= mdc_run_i ? ~mdc_o : 1'b0;
endmodule

// *** phy_strap_config_reset_test.sv ***
// Purpose: self-checking bench for strap loading and reset status
// Assumes: straps change only while reset is held
// Notes: every autoneg and config strap combination is loaded, read back and overwritten; reduced-if and mdix straps are random
`timescale 1ns/1ps
module phy_strap_config_reset_test;
    import pscr_pkg::*;
    logic        clk_i, rst_n_i, mdc_run, tst, scn, mdc;
    logic        wr, rd, done, byp, lpb, ane, mdx, rdo;
    logic [4:0]  sv, sp, addr;
    logic [15:0] wdata, rdata, d;
    logic [31:0] seed;
    pscr_adv_s   adv;
    int          error_cnt, n_tests;
    pscr_board u_board (.clk_i(clk_i), .straps_i(sv), .mdc_run_i(mdc_run), .straps_o(sp),
        .test_o(tst), .scan_o(scn), .mdc_o(mdc));
    pscr_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .autoneg_strap_i(sp[4]),
        .strap_config_a_i(sp[3]), .strap_config_b_i(sp[2]), .reduced_if_select_i(sp[1]),
        .mdix_dis_i(sp[0]), .test_i(tst), .scan_enable_pin_i(scn), .mdc_i(mdc),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .reset_done_o(done), .mlt3_bypass_o(byp), .loopback_o(lpb),
        .autoneg_en_o(ane), .auto_mdix_en_o(mdx), .reduced_if_o(rdo), .adv_o(adv));
    // 200 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // xorshift source and expected advertisement
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [3:0] adv_of(input logic a, input logic b);
        return (a ? (b ? 4'h8 : 4'h3) : (b ? 4'hc : 4'hf));
    endfunction
    // verdict and end of run
    task automatic tally_and_finish();
        $display("errors %0d tests %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // register port cycles
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk_i);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk_i);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
        @(posedge clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_i);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask
    // reset with new straps; the register port stays quiet until reset-done
    task automatic do_reset(input logic [4:0] v, input logic run);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        sv      <= v;
        mdc_run <= run;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (12) @(posedge clk_i);
    endtask
    task automatic wait_done();
        for (int k = 0; k < 400; k++)
        begin
            @(posedge clk_i);
            #1;
            if (done === 1'b1)
                return;
        end
        error_cnt++;
        $display("ERROR %0t reset-done never rose", $time);
        tally_and_finish();
    endtask
    // main sequence
    initial
    begin
        logic [31:0] r;
        logic        n, a, b;
        seed = 32'hd26d2c7c;
        error_cnt = 0;
        n_tests = 0;
        rst_n_i = 1'b0;
        mdc_run = 1'b0;
        sv = 5'h00;
        addr = 5'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        repeat (4) @(posedge clk_i);
        do_reset(5'h00, 1'b0);
        repeat (300) @(posedge clk_i);
        #1 chk(done, 1'b0);
        mdc_run <= 1'b1;
        wait_done();
        for (int i = 0; i < 8; i++)
        begin
            r = xs();
            n = i[2];
            a = i[1];
            b = i[0];
            do_reset({n, a, b, r[1:0]}, 1'b1);
            wait_done();
            chk(byp, !n & a);
            chk(lpb, !n & b);
            chk(ane, n);
            chk(adv, n ? adv_of(a, b) : 4'h0);
            chk(mdx, !r[0]);
            chk(rdo, r[1]);
            rd_reg(ADDR_BASIC_CONTROL, d);
            chk(d, {1'b0, !n & b, 1'b0, n, 12'h000});
            rd_reg(ADDR_PHY_CONFIG, d);
            chk(d, {14'h0000, !n & a, 1'b0});
            rd_reg(ADDR_STRAP_STATUS, d);
            chk(d, {10'h000, 1'b1, n, a, b, r[1:0]});
            rd_reg(5'h05, d);
            chk(d, 16'h0000);
            wr_reg(ADDR_PHY_CONFIG, {14'h0000, r[2], 1'b0});
            wr_reg(ADDR_BASIC_CONTROL, {1'b0, r[3], 3'h2, 11'h000});
            repeat (2) @(posedge clk_i);
            #1 chk(byp, r[2]);
            chk(lpb, r[3]);
            chk(ane, 1'b1);
            chk(adv, adv_of(a, b));
        end
        tally_and_finish();
    end
endmodule
bind pscr_top pscr_props u_props (.clk_i, .rst_n_i, .autoneg_strap_i, .strap_config_a_i,
    .strap_config_b_i, .reduced_if_select_i, .mdix_dis_i, .mdc_i, .reset_done_o,
    .mlt3_bypass_o, .loopback_o, .autoneg_en_o, .auto_mdix_en_o, .reduced_if_o, .adv_o);
